// >>> verilog/rsp_serial_port.sv
// mode-0 serial slave port in front of the rtc byte register map
// assumes serial clock far below clk_sys; storage answers one cycle after a read
`timescale 1ns/1ns

// How it works
// RQ1 - only mode 0 is supported: clock idles low, both sides agree.
// RQ2 - serial input is captured on each rising serial clock edge.
// RQ3 - serial output changes only after a falling serial clock edge.
// RQ4 - direction, address and write data all latch on rising edges.
// RQ5 - deselected: ignore clock and data, reset transfer, output high impedance.
// RQ6 - read output stays off until a byte is ready; writes never drive it.
// RQ7 - address pointer steps by one after every data byte, read or write.
// RQ8 - map holds 8 clock bytes, 17 control bytes, 7 user bytes.
// RQ9 - clock bytes are packed decimal; bad digits are flagged on write.
// RQ10 - square-wave setting counts as default 32 kHz until software writes it.
// RQ11 - first bit picks direction: one writes, zero reads.
// RQ12 - next seven bits give the start address, most significant first; only the low six are used.
// RQ13 - bursts continue while selected; pointer wraps from top to zero.
// RQ14 - master must drop chip select after power-on before any transfer; code arms anyway, as cs_s_ff resets to deselected.
// RQ15 - storage sees address, write enable, data and read data, one per byte.
// RQ16 - select, clock and data pass two flip-flops before edge detection.
module rsp_serial_port
  import rsp_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [5:0] reg_addr,
  output logic reg_rd_en,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_wr_ready,
  output logic reg_bcd_ok,
  output logic square_wave_default,
  output logic overrun
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] cs_s_ff;
  logic [1:0] sck_s_ff;
  logic [1:0] sin_s_ff;
  logic sck_d_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_ff <= 2'h3;
      sck_s_ff <= 2'h0;
      sin_s_ff <= 2'h0;
      sck_d_ff <= 1'b0;
    end else if (ce) begin
      cs_s_ff <= {cs_s_ff[0], cs_n}; // RQ16
      sck_s_ff <= {sck_s_ff[0], sclk}; // RQ16
      sin_s_ff <= {sin_s_ff[0], serial_in}; // RQ16
      sck_d_ff <= sck_s_ff[1];
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  rsp_state_e state_ff;
  rsp_state_e nxt_state;
  logic [2:0] bit_cnt_ff;
  logic [7:0] sh_in_ff;
  logic [7:0] sh_out_ff;
  logic [5:0] ptr_ff;
  logic armed_ff;
  logic rd_need_ff;
  logic rd_wait_ff;
  logic out_loaded_ff;
  logic push_ff;
  logic [FIFO_W-1:0] push_data_ff;
  logic cs_act;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic data_byte;
  logic drain;
  logic rd_issue;
  logic [7:0] nxt_sh_in;
  logic [5:0] nxt_ptr;
  logic [5:0] drain_addr;
  logic [7:0] drain_data;

  rsp_fifo_if #(.WIDTH(FIFO_W)) wq ();

  rsp_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .q(wq.fifo)
  );

  // mode 0 only: edges are found on the idle-low synchronised clock
  assign cs_act = ~cs_s_ff[1]; // RQ5
  assign sck_rise = cs_act & sck_s_ff[1] & ~sck_d_ff; // RQ1
  assign sck_fall = cs_act & ~sck_s_ff[1] & sck_d_ff; // RQ1
  assign nxt_sh_in = {sh_in_ff[6:0], sin_s_ff[1]}; // RQ2
  assign byte_done = sck_rise & (bit_cnt_ff == BIT_LAST);
  assign data_byte = byte_done & ((state_ff == RSP_RD) | (state_ff == RSP_WR));
  assign nxt_ptr = ptr_ff + 6'h01; // RQ13
  // reads wait for queued writes so a read never overtakes its own data
  assign drain = wq.out_valid & wq.out_ready;
  assign rd_issue = rd_need_ff & ~wq.out_valid;
  assign drain_addr = wq.out_data[FIFO_W-1:DATA_W];
  assign drain_data = wq.out_data[DATA_W-1:0];
  assign wq.in_valid = push_ff;
  assign wq.in_data = push_data_ff;
  assign wq.out_ready = reg_wr_ready; // RQ15

  // ----------------------------------------
  // transfer state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RSP_IDLE: if (cs_act && armed_ff) nxt_state = RSP_CMD; // RQ14
      RSP_CMD: begin
        if (byte_done) begin
          nxt_state = (nxt_sh_in[7] == DIR_WRITE) ? RSP_WR : RSP_RD; // RQ11
        end
      end
      RSP_RD: nxt_state = RSP_RD;
      RSP_WR: nxt_state = RSP_WR;
    endcase
    if (!cs_act) nxt_state = RSP_IDLE; // RQ5
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RSP_IDLE;
      armed_ff <= 1'b0;
      bit_cnt_ff <= BIT_FIRST;
      sh_in_ff <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      if (!cs_act) armed_ff <= 1'b1; // RQ14
      if (!cs_act || state_ff == RSP_IDLE) begin
        bit_cnt_ff <= BIT_FIRST; // RQ5
      end else if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        sh_in_ff <= nxt_sh_in; // RQ4
      end
    end
  end

  // ----------------------------------------
  // address pointer and write queue
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= ADDR_LOW;
      push_ff <= 1'b0;
      push_data_ff <= '0;
      overrun <= 1'b0;
    end else if (ce) begin
      push_ff <= 1'b0;
      if (state_ff == RSP_CMD && byte_done) begin
        ptr_ff <= nxt_sh_in[5:0]; // RQ12
      end else if (data_byte) begin
        ptr_ff <= nxt_ptr; // RQ7
      end
      // the master cannot be stalled, so a full queue loses the byte
      if (data_byte && state_ff == RSP_WR) begin
        if (wq.in_ready) begin
          push_ff <= 1'b1; // RQ4
          push_data_ff <= {ptr_ff, nxt_sh_in};
        end else begin
          overrun <= 1'b1;
        end
      end
      if (!cs_act) overrun <= 1'b0;
    end
  end

  // ----------------------------------------
  // storage access
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr <= ADDR_LOW;
      reg_rd_en <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_wdata <= 8'h00;
      reg_bcd_ok <= 1'b1;
      square_wave_default <= 1'b1;
    end else if (ce) begin
      reg_rd_en <= 1'b0;
      reg_wr_en <= 1'b0;
      if (drain) begin
        reg_addr <= drain_addr; // RQ15
        reg_wdata <= drain_data;
        reg_wr_en <= 1'b1;
        reg_bcd_ok <= (rsp_region(drain_addr) != RSP_RG_CLOCK) || // RQ8
                      rsp_bcd_ok(drain_data); // RQ9
        if (drain_addr == SQUARE_WAVE_ADDR) square_wave_default <= 1'b0; // RQ10
      end else if (rd_issue) begin
        reg_addr <= ptr_ff; // RQ15
        reg_rd_en <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read data and serial output
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_need_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      out_loaded_ff <= 1'b0;
      sh_out_ff <= 8'h00;
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else if (ce) begin
      rd_wait_ff <= reg_rd_en;
      if (rd_issue) rd_need_ff <= 1'b0;
      // prefetch the next byte as soon as the current one is done
      if ((state_ff == RSP_CMD && byte_done && !nxt_sh_in[7]) ||
          (state_ff == RSP_RD && byte_done)) begin
        rd_need_ff <= 1'b1; // RQ7
        out_loaded_ff <= 1'b0;
      end
      if (rd_wait_ff) begin
        sh_out_ff <= reg_rdata;
        out_loaded_ff <= 1'b1; // RQ6
      end
      if (state_ff == RSP_RD && sck_fall && out_loaded_ff) begin
        serial_out <= sh_out_ff[7]; // RQ3
        sh_out_ff <= {sh_out_ff[6:0], 1'b0};
        serial_out_oe_n <= 1'b0; // RQ6
      end
      if (!cs_act || state_ff != RSP_RD) serial_out_oe_n <= 1'b1; // RQ5
      if (!cs_act) begin
        rd_need_ff <= 1'b0;
        out_loaded_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  cs_hiz_out_a: // RQ5
  assert property (ce && !cs_act |=> serial_out_oe_n)
    else $error("serial output driven while deselected");
  wr_hiz_out_a: // RQ6
  assert property (ce && state_ff == RSP_WR |=> serial_out_oe_n)
    else $error("serial output driven during a write");
  out_on_fall_a: // RQ3
  assert property (!serial_out_oe_n && $changed(serial_out) |-> $past(sck_fall))
    else $error("serial output changed without a falling clock edge");
  ptr_step_a: // RQ7
  assert property (ce && data_byte |=> ptr_ff == $past(ptr_ff) + 6'h01)
    else $error("pointer did not step after a data byte");
  ptr_wrap_a: // RQ13
  assert property (ce && data_byte && ptr_ff == ADDR_TOP |=> ptr_ff == ADDR_LOW)
    else $error("pointer did not wrap to zero");
  dir_pick_a: // RQ11
  assert property (ce && cs_act && state_ff == RSP_CMD && byte_done
                   |=> (state_ff == RSP_WR) == $past(sh_in_ff[6]))
    else $error("direction bit not honoured");
  addr_load_a: // RQ12
  assert property (ce && state_ff == RSP_CMD && byte_done
                   |=> ptr_ff == {$past(sh_in_ff[4:0]), $past(sin_s_ff[1])})
    else $error("start address not loaded from command byte");
  wr_push_a: // RQ4
  assert property (ce && data_byte && state_ff == RSP_WR && wq.in_ready
                   |=> push_ff && push_data_ff[7:0] ==
                       {$past(sh_in_ff[6:0]), $past(sin_s_ff[1])})
    else $error("write byte not queued as shifted in");
  rd_issue_a: // RQ15
  assert property (ce && state_ff == RSP_CMD && byte_done && !sh_in_ff[6]
                   ##1 ce && !wq.out_valid |=> reg_rd_en && reg_addr == $past(ptr_ff))
    else $error("read not presented to storage");
  sync_idle_a: // RQ16
  assert property (ce && cs_s_ff[1] |=> state_ff == RSP_IDLE && bit_cnt_ff == BIT_FIRST)
    else $error("transfer state not reset on deselect");

  write_seen_c: cover property (reg_wr_en);
  read_seen_c: cover property (!serial_out_oe_n ##1 state_ff == RSP_RD);
  wrap_seen_c: cover property (data_byte && ptr_ff == ADDR_TOP);
  overrun_seen_c: cover property ($rose(overrun));
endmodule

// >>> pkg/rsp_pkg.sv
// constants, types and helpers for the rtc serial slave port
// assumes one system clock domain; the serial link is sampled, not clocked
package rsp_pkg;

  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int FIFO_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------
  // register map layout
  // ----------------------------------------
  localparam logic [5:0] ADDR_LOW = 6'h00;
  localparam logic [5:0] ADDR_TOP = 6'h3f;
  localparam int CLOCK_BYTES = 8;
  localparam int CTRL_BYTES = 17;
  localparam int USER_BYTES = 7;
  localparam logic [5:0] CTRL_BASE = 6'h08;
  localparam logic [5:0] USER_BASE = 6'h19;
  localparam logic [5:0] MAP_END = 6'h20;
  localparam logic [5:0] SQUARE_WAVE_ADDR = 6'h13;

  // ----------------------------------------
  // framing
  // ----------------------------------------
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [3:0] BCD_MAX = 4'h9;

  typedef enum logic [1:0] {
    RSP_IDLE = 2'b00,
    RSP_CMD = 2'b01,
    RSP_RD = 2'b11,
    RSP_WR = 2'b10
  } rsp_state_e;

  typedef enum logic [1:0] {
    RSP_RG_CLOCK = 2'b00,
    RSP_RG_CTRL = 2'b01,
    RSP_RG_USER = 2'b10,
    RSP_RG_NONE = 2'b11
  } rsp_region_e;

  function automatic rsp_region_e rsp_region(input logic [5:0] addr);
    if (addr < CTRL_BASE) return RSP_RG_CLOCK;
    if (addr < USER_BASE) return RSP_RG_CTRL;
    if (addr < MAP_END) return RSP_RG_USER;
    return RSP_RG_NONE;
  endfunction

  function automatic logic rsp_bcd_ok(input logic [7:0] val);
    return (val[7:4] <= BCD_MAX) && (val[3:0] <= BCD_MAX);
  endfunction

endpackage

// >>> pkg/rsp_fifo_if.sv
// write-queue handshake between the serial port and its fifo
// assumes both ends run on clk_sys
`timescale 1ns/1ns
interface rsp_fifo_if #(parameter int WIDTH = 14);
  logic [WIDTH-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] out_data;
  logic out_valid;
  logic out_ready;

  modport fifo (
    input in_data,
    input in_valid,
    output in_ready,
    output out_data,
    output out_valid,
    input out_ready
  );

  modport user (
    output in_data,
    output in_valid,
    input in_ready,
    input out_data,
    input out_valid,
    output out_ready
  );
endinterface

// >>> verilog/rsp_fifo.sv
// small synchronous fifo, valid/ready on both sides
// assumes DEPTH is a power of two; ce low freezes it
`timescale 1ns/1ns
module rsp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  rsp_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // extra pointer bit tells full from empty
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign q.in_ready = ~full;
  assign q.out_valid = ~empty;
  assign q.out_data = mem[rd_ptr_ff[AW-1:0]];
  assign do_wr = ce & q.in_valid & ~full;
  assign do_rd = ce & q.out_ready & ~empty;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_wr) wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      if (do_rd) rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_wr) mem[wr_ptr_ff[AW-1:0]] <= q.in_data;
  end
endmodule

// >>> verification/rsp_spi_master.sv
// mode-0 spi master model for the rtc serial slave port
// assumes it alone drives cs_n, sclk and serial_in; the bench calls its tasks
`timescale 1ns/1ns
module rsp_spi_master (
  output logic cs_n,
  output logic sclk,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // ----------------------------------------
  // link driving
  // ----------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end

  task automatic start();
    cs_n = 1'b0;
    #62;
  endtask

  // data set while clock low and held across the rise
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      serial_in = tx[i];
      #62 sclk = 1'b1;
      rx[i] = serial_out_oe_n ? 1'bx : serial_out;
      #63 sclk = 1'b0;
    end
  endtask

  task automatic stop();
    #62 cs_n = 1'b1;
    // a stale bit must not look like fresh data
    serial_in = ~serial_in;
    #250;
  endtask
endmodule

// >>> verification/rtc_serial_slave_port_test.sv
// self-checking bench for rsp_serial_port with a byte storage model
// assumes the spi master model drives the link asynchronously
`timescale 1ns/1ns
module rtc_serial_slave_port_test;
  import rsp_pkg::*;
  typedef struct {logic [6:0] a; logic [7:0] d; logic dflt;} rsp_row_s;
  logic clk_sys, rst_n, ce, cs_n, sclk, serial_in, serial_out, serial_out_oe_n;
  logic reg_rd_en, reg_wr_en, reg_wr_ready, reg_bcd_ok, square_wave_default, overrun;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] mem [64];
  logic [7:0] txb [16];
  logic [7:0] rxb [16];
  logic wr_frm, exp_bcd;
  int mismatches, comparisons, wr_cnt, hi_cnt, cyc, w0;
  rsp_row_s rows [6] = '{'{7'h00, 8'h59, 1'b1}, '{7'h41, 8'h3a, 1'b1},
    '{7'h07, 8'h99, 1'b1}, '{7'h13, 8'h20, 1'b0}, '{7'h1f, 8'ha5, 1'b0},
    '{7'h3f, 8'h5a, 1'b0}};

  rsp_serial_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cs_n(cs_n),
    .sclk(sclk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_wr_ready(reg_wr_ready), .reg_bcd_ok(reg_bcd_ok),
    .square_wave_default(square_wave_default), .overrun(overrun));

  rsp_spi_master m (.cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

  // ----------------------------------------
  // clock, storage model and monitors
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (reg_wr_en === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt++;
    end
    if (reg_rd_en === 1'b1) reg_rdata <= mem[reg_addr];
    hi_cnt = cs_n ? hi_cnt + 1 : 0;
    if (hi_cnt > 8 && serial_out_oe_n !== 1'b1) check("oe_desel", 0, 1);
    if (wr_frm && serial_out_oe_n !== 1'b1) check("oe_write", 0, 1);
    // whole run is near 7000 cycles
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic burst(input logic dir, input logic [6:0] a, input int n);
    logic [7:0] rx;
    wr_frm = dir;
    m.start();
    m.shift({dir, a}, 8, rx);
    for (int i = 0; i < n; i++) begin
      m.shift(dir ? txb[i] : 8'h00, 8, rxb[i]);
    end
  endtask

  task automatic fin();
    m.stop();
    wr_frm = 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr_ready = 1'b1;
    reg_rdata = 8'h00;
    wr_frm = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    repeat (10) @(negedge clk_sys);
    check("rst_out", {serial_out_oe_n, reg_rd_en, reg_wr_en, reg_bcd_ok, square_wave_default,
      overrun, reg_addr[1:0]}, 8'b1001_1000);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (int r = 0; r < 6; r++) begin
      txb[0] = rows[r].d;
      burst(1'b1, rows[r].a, 1);
      fin();
      check("mem", mem[rows[r].a[5:0]], rows[r].d);
      // only the clock bytes are held to packed decimal
      exp_bcd = (rows[r].a[5:0] >= CTRL_BASE) ||
        ((rows[r].d[7:4] <= 4'h9) && (rows[r].d[3:0] <= 4'h9));
      check("bcd", reg_bcd_ok, exp_bcd);
      check("square_dflt", square_wave_default, rows[r].dflt);
      burst(1'b0, rows[r].a, 1);
      fin();
      check("rx", rxb[0], rows[r].d);
    end
    // burst across the top of the map, both directions
    for (int i = 0; i < 3; i++) txb[i] = 8'h11 * (i + 1);
    burst(1'b1, 7'h3e, 3);
    fin();
    for (int i = 0; i < 3; i++) check("wrap_wr", mem[(i + 62) % 64], txb[i]);
    burst(1'b0, 7'h3e, 3);
    fin();
    for (int i = 0; i < 3; i++) check("wrap_rd", rxb[i], txb[i]);
    // partial byte dropped, clocking while deselected ignored
    w0 = wr_cnt;
    m.start();
    m.shift(8'h85, 8, rxb[0]);
    m.shift(8'hff, 4, rxb[0]);
    m.stop();
    m.shift(8'h86, 8, rxb[0]);
    m.shift(8'hff, 8, rxb[0]);
    #500;
    check("partial", wr_cnt - w0, 0);
    check("mem05", mem[5], 8'h00);
    // stalled storage: fifo takes 8 bytes, the rest are lost
    @(negedge clk_sys);
    reg_wr_ready = 1'b0;
    for (int i = 0; i < 10; i++) txb[i] = 8'h40 + i;
    w0 = wr_cnt;
    burst(1'b1, 7'h20, 10);
    #300;
    check("ovr_set", overrun, 1'b1);
    check("stall", wr_cnt - w0, 0);
    fin();
    check("ovr_clr", overrun, 1'b0);
    @(negedge clk_sys);
    reg_wr_ready = 1'b1;
    for (int k = 0; k < 200 && wr_cnt < w0 + 8; k++) @(negedge clk_sys);
    repeat (20) @(negedge clk_sys);
    check("drain", wr_cnt - w0, 8);
    for (int i = 0; i < 10; i++) check("fifo", mem[32 + i], i < 8 ? txb[i] : 8'h00);
    stop_test();
  end
endmodule
